/* design/acp_top.sv */
`timescale 1ns/1ps
`include "acp_defs.svh"

// Function
// - result register is read-only, resets to zero
// - result reads cost one bus wait cycle
// - three-bit code picks inputs zero to four
// - selector writes cost one bus wait cycle
// - pin config bit: zero analog, one digital
// - pin config resets to all analog
// - pin config writes cost one wait cycle
// - direction bit zero drives, one inputs; resets ones
// - amplifier output drives input one when enabled and that pin is an analog input
// - unselected analog pin stays unconverted analog input
// - conversion end loads result register
// - selector write during conversion restarts it
module acp_top (
    input wire logic clk,
    input wire logic reset_n,
    input wire acp_pkg::acp_bus_req_type bus_req,
    output logic [7:0] bus_rdata,
    output logic bus_wait,
    input wire logic periph_clk_run,
    input wire logic amplifier_enable,
    input wire acp_pkg::acp_conv_in_type conv_in,
    output logic [2:0] channel_code,
    output logic conv_restart,
    output logic [7:0] pin_digital,
    output logic [7:0] pin_out_en,
    output logic [4:0] convert_select,
    output logic amp_drive_pin1,
    output logic [1:0] status_flags,
    input wire logic [7:0] port2_pin_in
);
    import acp_pkg::*;

    acp_state_type state_q; // registered state
    acp_state_type state_d; // next state

    logic wr_chan; // write to channel selector
    logic wr_dir; // write to direction register
    logic wr_cfg; // write to pin configuration
    logic wr_stat; // write-one-to-clear of status
    logic rd_result; // read of result register
    logic slow_access; // access that costs a wait cycle
    logic wait_flag; // wait generator output
    logic stop_err; // access while peripheral clock stopped
    logic [4:0] mux_sel; // decoded conversion pin
    logic mux_amp; // decoded amplifier drive
    logic mux_bad; // decoded prohibited setting
    logic [7:0] lvl_change; // synchroniser stages disagree
    logic [2:0] chan_next; // channel selector after this cycle's write
    logic [7:0] cfg_next; // pin configuration after this cycle's write
    logic [7:0] dir_next; // direction after this cycle's write

    // address decode, strobes are never both high
    assign wr_chan = bus_req.wr && (bus_req.addr == `ACP_ADDR_CHANNEL);
    assign wr_dir = bus_req.wr && (bus_req.addr == `ACP_ADDR_DIRECTION);
    assign wr_cfg = bus_req.wr && (bus_req.addr == `ACP_ADDR_PIN_CONFIG);
    assign wr_stat = bus_req.wr && (bus_req.addr == `ACP_ADDR_STATUS);
    assign rd_result = bus_req.rd && (bus_req.addr == `ACP_ADDR_RESULT);

    // next register values built apart from the state copy, so the
    // decode below never reads the process that consumes its result
    assign chan_next = wr_chan ? bus_req.wdata[`ACP_CHAN_MSB:`ACP_CHAN_LSB]
        : state_q.chan;
    assign cfg_next = wr_cfg ? bus_req.wdata : state_q.pin_cfg;
    assign dir_next = wr_dir ? bus_req.wdata : state_q.dir;

    // result reads and selector or config writes are the slow ones
    assign slow_access = rd_result || wr_chan || wr_cfg;

    // wait cycle flag and stopped-clock detection
    acp_wait_gen u_wait (
        .clk(clk),
        .reset_n(reset_n),
        .slow_access(slow_access),
        .periph_clk_run(periph_clk_run),
        .bus_wait(wait_flag),
        .stop_err(stop_err)
    );

    // pin function decode from the next register values, so the
    // registered outputs line up with the registers themselves
    acp_pin_mux #(
        .NUM_ANALOG(`ACP_NUM_ANALOG)
    ) u_mux (
        .pin_cfg(cfg_next),
        .dir(dir_next),
        .chan(chan_next),
        .amp_en(amplifier_enable),
        .conv_sel(mux_sel),
        .amp_drive(mux_amp),
        .cfg_bad(mux_bad)
    );

    // stages two and three disagree: hold the filtered level
    assign lvl_change = state_q.sync2 ^ state_q.sync3;

    // next-state logic
    always_comb
    begin
        state_d = state_q;

        // conversion end loads the approximation result
        if (conv_in.done)
        begin
            state_d.result = conv_in.sar;
        end

        // channel selector keeps only the code field
        if (wr_chan)
        begin
            state_d.chan = bus_req.wdata[`ACP_CHAN_MSB:`ACP_CHAN_LSB];
        end
        // restart pulse only while a conversion runs
        state_d.restart = wr_chan && conv_in.busy;

        // pin configuration, every bit writable
        if (wr_cfg)
        begin
            state_d.pin_cfg = bus_req.wdata;
        end

        // port direction
        if (wr_dir)
        begin
            state_d.dir = bus_req.wdata;
        end
        // output buffer on where the direction bit is zero
        state_d.oe = ~state_d.dir;

        // registered pin function
        state_d.conv_sel = mux_sel;
        state_d.amp_drive = mux_amp;

        // sticky status: clear by writing one, a new event wins the clear
        if (wr_stat)
        begin
            state_d.status = state_q.status & ~bus_req.wdata[1:0];
        end
        if (stop_err)
        begin
            state_d.status[`ACP_STAT_CLK_STOP] = 1'b1;
        end
        if (mux_bad && conv_in.busy)
        begin
            state_d.status[`ACP_STAT_CFG_BAD] = 1'b1;
        end

        // pin synchroniser; stage one is only read by stage two
        state_d.sync1 = port2_pin_in;
        state_d.sync2 = state_q.sync1;
        state_d.sync3 = state_q.sync2;
        state_d.pin_lvl = (~lvl_change & state_q.sync3) | (lvl_change & state_q.pin_lvl);

        // read data stand for one cycle only, zero otherwise
        state_d.rdata = 8'h00;
        if (bus_req.rd)
        begin
            unique case (bus_req.addr)
                `ACP_ADDR_RESULT:
                begin
                    state_d.rdata = state_q.result;
                end
                `ACP_ADDR_CHANNEL:
                begin
                    // upper bits read as zero
                    state_d.rdata = {5'h00, state_q.chan};
                end
                `ACP_ADDR_PIN_CONFIG:
                begin
                    state_d.rdata = state_q.pin_cfg;
                end
                `ACP_ADDR_DIRECTION:
                begin
                    state_d.rdata = state_q.dir;
                end
                `ACP_ADDR_STATUS:
                begin
                    state_d.rdata = {6'h00, state_q.status};
                end
                `ACP_ADDR_PIN_LEVEL:
                begin
                    state_d.rdata = state_q.pin_lvl;
                end
                default:
                begin
                    // unmapped addresses read zero
                    state_d.rdata = 8'h00;
                end
            endcase
        end
    end

    // state register with fixed reset values
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_q <= '0;
            state_q.result <= `ACP_RESULT_RESET;
            state_q.chan <= `ACP_CHANNEL_RESET;
            state_q.pin_cfg <= `ACP_PIN_CONFIG_RESET;
            state_q.dir <= `ACP_DIRECTION_RESET;
            state_q.oe <= 8'h00;
            state_q.status <= `ACP_STATUS_RESET;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    // outputs straight from flip-flops
    assign bus_rdata = state_q.rdata;
    assign bus_wait = wait_flag;
    assign channel_code = state_q.chan;
    assign conv_restart = state_q.restart;
    assign pin_digital = state_q.pin_cfg;
    assign pin_out_en = state_q.oe;
    assign convert_select = state_q.conv_sel;
    assign amp_drive_pin1 = state_q.amp_drive;
    assign status_flags = state_q.status;

    // result follows the approximation value one cycle after done
    result_load_a: assert property (@(posedge clk) disable iff (!reset_n)
        conv_in.done |=> (state_q.result == $past(conv_in.sar)))
        else $error("result not loaded at conversion end");

    // writes cannot change the result register
    result_ro_a: assert property (@(posedge clk) disable iff (!reset_n)
        (bus_req.wr && (bus_req.addr == `ACP_ADDR_RESULT) && !conv_in.done)
        |=> $stable(state_q.result))
        else $error("result register changed by a write");

    // result read returns the stored value in the next cycle only
    result_read_a: assert property (@(posedge clk) disable iff (!reset_n)
        (rd_result && !conv_in.done) |=> (bus_rdata == state_q.result)
        ##1 ((bus_rdata == 8'h00) || $past(bus_req.rd)))
        else $error("result read data wrong");

    // channel code takes the low three bits of the write
    chan_write_a: assert property (@(posedge clk) disable iff (!reset_n)
        wr_chan |=> (channel_code == $past(bus_req.wdata[2:0])))
        else $error("channel code not updated");

    // restart is a single pulse after a write during conversion
    restart_pulse_a: assert property (@(posedge clk) disable iff (!reset_n)
        (wr_chan && conv_in.busy) ##1 !wr_chan |-> conv_restart ##1 !conv_restart)
        else $error("conversion restart pulse wrong");

    // no restart without a selector write
    restart_cause_a: assert property (@(posedge clk) disable iff (!reset_n)
        !wr_chan |=> !conv_restart)
        else $error("spurious conversion restart");

    // output enable is the inverse of the written direction
    dir_drive_a: assert property (@(posedge clk) disable iff (!reset_n)
        wr_dir |=> (pin_out_en == ~$past(bus_req.wdata)))
        else $error("output enable does not follow direction");

    // after reset all pins are analog inputs with buffers off
    reset_state_a: assert property (@(posedge clk)
        $rose(reset_n) |-> (pin_digital == 8'h00) && (pin_out_en == 8'h00)
        && (bus_rdata == 8'h00) && (channel_code == 3'h0))
        else $error("wrong state after reset");

    // amplifier drive tracks analog input one and the enable
    amp_drive_a: assert property (@(posedge clk) disable iff (!reset_n)
        ##1 (amp_drive_pin1 == (!pin_digital[1] && !pin_out_en[1]
        && $past(amplifier_enable)))) 
        else $error("amplifier drive mismatch");

    // a converted pin is the chosen analog input pin
    conv_pick_a: assert property (@(posedge clk) disable iff (!reset_n)
        (convert_select != 5'h00) |-> $onehot(convert_select)
        && (convert_select[channel_code] == 1'b1) && !pin_digital[channel_code])
        else $error("conversion select inconsistent");

    // stopped-clock error is sticky until cleared
    stat_sticky_a: assert property (@(posedge clk) disable iff (!reset_n)
        stop_err |=> status_flags[`ACP_STAT_CLK_STOP])
        else $error("clock stop flag not set");
endmodule

/* shared/acp_defs.svh */
`ifndef ACP_DEFS_SVH
`define ACP_DEFS_SVH

// register byte addresses on the 16-bit register port
`define ACP_ADDR_CHANNEL 16'hFF0E
`define ACP_ADDR_DIRECTION 16'hFF22
`define ACP_ADDR_PIN_CONFIG 16'hFF97
`define ACP_ADDR_RESULT 16'hFF1F
`define ACP_ADDR_STATUS 16'hFF98
`define ACP_ADDR_PIN_LEVEL 16'hFF02

// reset values
`define ACP_RESULT_RESET 8'h00
`define ACP_CHANNEL_RESET 3'h0
`define ACP_PIN_CONFIG_RESET 8'h00
`define ACP_DIRECTION_RESET 8'hFF
`define ACP_STATUS_RESET 2'h0

// field positions and limits
`define ACP_CHAN_MSB 2
`define ACP_CHAN_LSB 0
`define ACP_CHAN_MAX 3'h4
`define ACP_NUM_ANALOG 5
`define ACP_AMP_OUT_PIN 1
`define ACP_AMP_IN_PIN_A 0
`define ACP_AMP_IN_PIN_B 2
`define ACP_STAT_CLK_STOP 0
`define ACP_STAT_CFG_BAD 1

// bus wait cycles inserted per slow access
`define ACP_WAIT_CYCLES 1

`endif

/* shared/acp_pkg.sv */
package acp_pkg;

    // one register port request, all fields valid in the same cycle
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } acp_bus_req_type;

    // signals from the conversion sequencer
    typedef struct packed {
        logic done;
        logic busy;
        logic [7:0] sar;
    } acp_conv_in_type;

    // wait generator states, one-hot
    typedef enum logic [1:0] {
        ACP_WG_IDLE = 2'b01,
        ACP_WG_WAIT = 2'b10
    } acp_wait_state_type;

    // wait generator state
    typedef struct packed {
        acp_wait_state_type state;
        logic wait_flag;
        logic stop_err;
    } acp_wait_reg_type;

    // main block state
    typedef struct packed {
        logic [7:0] result;
        logic [2:0] chan;
        logic [7:0] pin_cfg;
        logic [7:0] dir;
        logic [7:0] oe;
        logic [7:0] rdata;
        logic restart;
        logic [1:0] status;
        logic [4:0] conv_sel;
        logic amp_drive;
        logic [7:0] sync1;
        logic [7:0] sync2;
        logic [7:0] sync3;
        logic [7:0] pin_lvl;
    } acp_state_type;

endpackage

/* design/acp_wait_gen.sv */
`timescale 1ns/1ps
`include "acp_defs.svh"

// flags one bus wait cycle per slow access and catches slow accesses with the
// peripheral clock stopped; the master is never held, the flag is advisory
module acp_wait_gen (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic slow_access,
    input wire logic periph_clk_run,
    output logic bus_wait,
    output logic stop_err
);
    import acp_pkg::*;

    acp_wait_reg_type st_q; // registered state
    acp_wait_reg_type st_d; // next state

    // next-state logic
    always_comb
    begin
        st_d = st_q;
        st_d.wait_flag = 1'b0;
        st_d.stop_err = 1'b0;
        unique case (st_q.state)
            ACP_WG_IDLE:
            begin
                // one wait cycle per access
                if (slow_access)
                begin
                    st_d.state = ACP_WG_WAIT;
                    st_d.wait_flag = 1'b1;
                    st_d.stop_err = !periph_clk_run;
                end
            end
            ACP_WG_WAIT:
            begin
                // back-to-back access keeps the wait asserted
                st_d.state = slow_access ? ACP_WG_WAIT : ACP_WG_IDLE;
                st_d.wait_flag = slow_access;
                st_d.stop_err = slow_access && !periph_clk_run;
            end
            default:
            begin
                st_d.state = ACP_WG_IDLE;
            end
        endcase
    end

    // state register
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            st_q <= '0;
            st_q.state <= ACP_WG_IDLE;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign bus_wait = st_q.wait_flag;
    assign stop_err = st_q.stop_err;

    // each slow access flags exactly its wait cycle
    wait_pulse_a: assert property (@(posedge clk) disable iff (!reset_n)
        slow_access |=> bus_wait)
        else $error("no wait cycle after slow access");

    // a stopped clock during access is reported
    clock_stop_a: assert property (@(posedge clk) disable iff (!reset_n)
        (slow_access && !periph_clk_run) |=> stop_err)
        else $error("stopped clock access not reported");
endmodule

/* design/acp_pin_mux.sv */
`timescale 1ns/1ps
`include "acp_defs.svh"

// decodes per-pin function from the configuration, direction, channel code
// and amplifier enable; purely combinational, the top registers the result
module acp_pin_mux #(
    parameter int NUM_ANALOG = `ACP_NUM_ANALOG
) (
    input wire logic [7:0] pin_cfg,
    input wire logic [7:0] dir,
    input wire logic [2:0] chan,
    input wire logic amp_en,
    output logic [NUM_ANALOG-1:0] conv_sel,
    output logic amp_drive,
    output logic cfg_bad
);
    import acp_pkg::*;

    logic [NUM_ANALOG-1:0] analog_in; // pin is analog and in input mode
    logic [NUM_ANALOG-1:0] picked; // channel code names this pin
    logic amp_clash; // amplifier input pin chosen for conversion
    logic chan_illegal; // code above the last input

    // per-input decode
    genvar gi;
    generate
        for (gi = 0; gi < NUM_ANALOG; gi++)
        begin : g_pin
            assign analog_in[gi] = !pin_cfg[gi] && dir[gi];
            assign picked[gi] = (chan == 3'(gi));
            // only the picked analog input is converted, others stay analog
            assign conv_sel[gi] = picked[gi] && analog_in[gi];
        end
    endgenerate

    // amplifier output takes over input one when it is analog input
    assign amp_drive = analog_in[`ACP_AMP_OUT_PIN] && amp_en;

    assign chan_illegal = (chan > `ACP_CHAN_MAX);
    assign amp_clash = amp_en && (picked[`ACP_AMP_IN_PIN_A] || picked[`ACP_AMP_IN_PIN_B]);
    // prohibited combinations, reported but not blocked
    assign cfg_bad = chan_illegal || amp_clash || ((picked & ~analog_in) != '0);
endmodule

/* design/acp_top_dummy_check.sv */
`timescale 1ns/1ps

/* verification/acp_tb.sv */
`timescale 1ns/1ps
`include "acp_defs.svh"

module tb;
    import acp_pkg::*;

    logic clk;
    logic reset_n;
    acp_bus_req_type bus_req;
    logic [7:0] bus_rdata;
    logic bus_wait;
    logic periph_clk_run;
    logic amplifier_enable;
    acp_conv_in_type conv_in;
    logic [2:0] channel_code;
    logic conv_restart;
    logic [7:0] pin_digital;
    logic [7:0] pin_out_en;
    logic [4:0] convert_select;
    logic amp_drive_pin1;
    logic [1:0] status_flags;
    logic [7:0] port2_pin_in;
    // mismatch and comparison counts
    int miscompares = 0;
    int num_checks = 0;
    logic [7:0] rd_val;
    logic wt;

    acp_top acp_top_i (
        .clk(clk),
        .reset_n(reset_n),
        .bus_req(bus_req),
        .bus_rdata(bus_rdata),
        .bus_wait(bus_wait),
        .periph_clk_run(periph_clk_run),
        .amplifier_enable(amplifier_enable),
        .conv_in(conv_in),
        .channel_code(channel_code),
        .conv_restart(conv_restart),
        .pin_digital(pin_digital),
        .pin_out_en(pin_out_en),
        .convert_select(convert_select),
        .amp_drive_pin1(amp_drive_pin1),
        .status_flags(status_flags),
        .port2_pin_in(port2_pin_in)
    );

    // 125 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // one compare, counted; mismatch reported at once
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
            miscompares++;
        end
    endtask

    // one-cycle write strobe; wait flag sampled the cycle after
    task automatic bus_write(input logic [15:0] a, input logic [7:0] d, output logic w);
        @(posedge clk);
        bus_req <= '{a, d, 1'b1, 1'b0};
        @(posedge clk);
        bus_req.wr <= 1'b0;
        #1;
        w = bus_wait;
    endtask

    // one-cycle read strobe; data stands only in the next cycle
    task automatic bus_read(input logic [15:0] a, output logic [7:0] d, output logic w);
        @(posedge clk);
        bus_req <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clk);
        bus_req.rd <= 1'b0;
        #1;
        d = bus_rdata;
        w = bus_wait;
    endtask

    // let registered pin decode follow the registers
    task automatic settle();
        repeat (2) @(posedge clk);
        #1;
    endtask

    // verdict, reached by the main sequence or the watchdog
    task automatic final_report();
        $display("checks=%0d miscompares=%0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // register reset values, unmapped read, wait on result read
    task automatic t_reset_values();
        bus_read(`ACP_ADDR_RESULT, rd_val, wt);
        chk(rd_val, 8'h00);
        chk({7'h00, wt}, 8'h01);
        bus_read(`ACP_ADDR_CHANNEL, rd_val, wt);
        chk(rd_val, 8'h00);
        chk({7'h00, wt}, 8'h00);
        bus_read(`ACP_ADDR_PIN_CONFIG, rd_val, wt);
        chk(rd_val, 8'h00);
        bus_read(`ACP_ADDR_DIRECTION, rd_val, wt);
        chk(rd_val, 8'hFF);
        bus_read(16'hFF00, rd_val, wt);
        chk(rd_val, 8'h00);
        chk(pin_out_en, 8'h00);
        chk(pin_digital, 8'h00);
        chk({3'h0, convert_select}, 8'h01);
    endtask

    // every legal code, upper bits always written as zero
    task automatic t_channel_codes();
        for (int i = 0; i < 5; i++)
        begin
            bus_write(`ACP_ADDR_CHANNEL, 8'(i), wt);
            chk({7'h00, wt}, 8'h01);
            chk({5'h00, channel_code}, 8'(i));
            settle();
            chk({3'h0, convert_select}, 8'(1 << i));
        end
        bus_read(`ACP_ADDR_CHANNEL, rd_val, wt);
        chk(rd_val, 8'h04);
    endtask

    // digital pin is never converted; other pins unaffected
    task automatic t_pin_config();
        bus_write(`ACP_ADDR_PIN_CONFIG, 8'h02, wt);
        chk({7'h00, wt}, 8'h01);
        chk(pin_digital, 8'h02);
        settle();
        chk({3'h0, convert_select}, 8'h10);
        bus_write(`ACP_ADDR_CHANNEL, 8'h01, wt);
        settle();
        chk({3'h0, convert_select}, 8'h00);
        bus_read(`ACP_ADDR_PIN_CONFIG, rd_val, wt);
        chk(rd_val, 8'h02);
        bus_write(`ACP_ADDR_PIN_CONFIG, 8'h00, wt);
        settle();
        chk({3'h0, convert_select}, 8'h02);
    endtask

    // output-mode pin drives and is not converted
    task automatic t_direction();
        bus_write(`ACP_ADDR_DIRECTION, 8'hFD, wt);
        chk({7'h00, wt}, 8'h00);
        chk(pin_out_en, 8'h02);
        settle();
        chk({3'h0, convert_select}, 8'h00);
        bus_read(`ACP_ADDR_DIRECTION, rd_val, wt);
        chk(rd_val, 8'hFD);
        bus_write(`ACP_ADDR_DIRECTION, 8'hFF, wt);
        settle();
        chk(pin_out_en, 8'h00);
        chk({3'h0, convert_select}, 8'h02);
    endtask

    // amplifier output on input one, converted only when chosen
    task automatic t_amplifier();
        @(posedge clk);
        amplifier_enable <= 1'b1;
        settle();
        chk({7'h00, amp_drive_pin1}, 8'h01);
        chk({3'h0, convert_select}, 8'h02);
        bus_write(`ACP_ADDR_CHANNEL, 8'h03, wt);
        settle();
        chk({7'h00, amp_drive_pin1}, 8'h01);
        chk({3'h0, convert_select}, 8'h08);
        @(posedge clk);
        amplifier_enable <= 1'b0;
        settle();
        chk({7'h00, amp_drive_pin1}, 8'h00);
    endtask

    // conversion end loads result; writes to result ignored
    task automatic t_result_load();
        @(posedge clk);
        conv_in <= '{1'b1, 1'b0, 8'hA5};
        @(posedge clk);
        conv_in.done <= 1'b0;
        bus_read(`ACP_ADDR_RESULT, rd_val, wt);
        chk(rd_val, 8'hA5);
        chk({7'h00, wt}, 8'h01);
        bus_write(`ACP_ADDR_RESULT, 8'h3C, wt);
        bus_read(`ACP_ADDR_RESULT, rd_val, wt);
        chk(rd_val, 8'hA5);
    endtask

    // selector write while busy restarts, while idle does not
    task automatic t_restart();
        @(posedge clk);
        conv_in.busy <= 1'b1;
        bus_write(`ACP_ADDR_CHANNEL, 8'h02, wt);
        chk({7'h00, conv_restart}, 8'h01);
        chk({5'h00, channel_code}, 8'h02);
        @(posedge clk);
        conv_in.busy <= 1'b0;
        #1;
        chk({7'h00, conv_restart}, 8'h00);
        bus_write(`ACP_ADDR_CHANNEL, 8'h00, wt);
        chk({7'h00, conv_restart}, 8'h00);
    endtask

    // access with clock stopped and prohibited code while busy flagged
    task automatic t_status();
        @(posedge clk);
        periph_clk_run <= 1'b0;
        bus_read(`ACP_ADDR_RESULT, rd_val, wt);
        @(posedge clk);
        periph_clk_run <= 1'b1;
        settle();
        chk({6'h00, status_flags}, 8'h01);
        bus_write(`ACP_ADDR_STATUS, 8'h01, wt);
        settle();
        chk({6'h00, status_flags}, 8'h00);
        @(posedge clk);
        conv_in.busy <= 1'b1;
        bus_write(`ACP_ADDR_CHANNEL, 8'h05, wt);
        settle();
        chk({6'h00, status_flags}, 8'h02);
        bus_write(`ACP_ADDR_CHANNEL, 8'h00, wt);
        @(posedge clk);
        conv_in.busy <= 1'b0;
        bus_write(`ACP_ADDR_STATUS, 8'h02, wt);
        settle();
        chk({6'h00, status_flags}, 8'h00);
    endtask

    // synchronised pin levels readable
    task automatic t_pin_level();
        @(posedge clk);
        port2_pin_in <= 8'h5A;
        repeat (6) @(posedge clk);
        bus_read(`ACP_ADDR_PIN_LEVEL, rd_val, wt);
        chk(rd_val, 8'h5A);
    endtask

    // watchdog against a hung run
    initial
    begin
        repeat (5000) @(posedge clk);
        miscompares++;
        final_report();
    end

    // main sequence
    initial
    begin
        reset_n = 1'b0;
        bus_req = '0;
        conv_in = '0;
        periph_clk_run = 1'b1;
        amplifier_enable = 1'b0;
        port2_pin_in = 8'h00;
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        settle();
        t_reset_values();
        t_channel_codes();
        t_pin_config();
        t_direction();
        t_amplifier();
        t_result_load();
        t_restart();
        t_status();
        t_pin_level();
        final_report();
    end
endmodule
